// ==== common/tester_cmd_pkg.sv ====
// Constants and types for the remote command handler
// What this block does
// - Bus trigger acts only on measurement page and while idle.
// - Bus trigger needs bus source; starts device measurement only.
// - Four trigger sources: manual, internal repeat, handler, bus; query returns one.
// - Waveform fetch before data ready is held until a measurement completes.
// - Comparison query answers 2 when comparator or all methods are off.
// - Comparison query answers 3 when no waveform data is available.
// - Comparison answer: verdict then four method results in fixed order.
// - Disabled methods report the no-value code, discharge reports 9999.
// - Voltage fetch answers the measured volts.
// - Frequency and time fetches; coincident cursors give the no-value code for frequency only.
// - Statistics answer is ten words: totals and passes, overall then per method.
// - Voltage limits 1 to 255; lower not below upper is an error.
// - Frequency and time points 1 to 600; end must exceed start.
// - Frequency and time share one range.
// - Abort ends any running measurement at once.
// - File commands are discarded while testing.
// - Record numbers 1 to 60; range and missing-file errors.
// - Loading restores the page stored with the record.
// - Store keeps a name under 12 characters, default when empty, error if longer; overwrite silently.
// - Store without reference waveform raises a warning.
// - Delete of an empty record raises no message.
// - Parse errors discard the rest of the line; ignored commands do not.
// - Handler source starts on rising edge of the active-low start input.
package tester_cmd_pkg;
  typedef enum logic [4:0] {
    CMD_TRIG = 5'h00, CMD_SRC_SET = 5'h01, CMD_SRC_Q = 5'h02,
    CMD_FETCH_REF = 5'h03, CMD_FETCH_MEAS = 5'h04, CMD_FETCH_CMP = 5'h05,
    CMD_FETCH_VOLT = 5'h06, CMD_FETCH_FREQ = 5'h07, CMD_FETCH_TIME = 5'h08,
    CMD_FETCH_STAT = 5'h09, CMD_VOLT_SET = 5'h0A, CMD_VOLT_Q = 5'h0B,
    CMD_FREQ_SET = 5'h0C, CMD_TIME_SET = 5'h0D, CMD_FREQ_Q = 5'h0E,
    CMD_TIME_Q = 5'h0F, CMD_ABORT = 5'h10, CMD_LOAD = 5'h11,
    CMD_STORE = 5'h12, CMD_DELETE = 5'h13
  } cmd_t;
  typedef enum logic [1:0] {
    SRC_MAN = 2'h0, SRC_INT = 2'h1, SRC_EXT = 2'h2, SRC_BUS = 2'h3
  } trig_src_t;
  typedef enum logic [3:0] {
    MSG_NONE = 4'h0, MSG_SYNTAX = 4'h1, MSG_RANGE = 4'h2, MSG_ORDER = 4'h3,
    MSG_TOO_LONG = 4'h4, MSG_FILE_RANGE = 4'h5, MSG_NO_FILE = 4'h6,
    MSG_NEED_REF = 4'h7, MSG_CMD_IGN = 4'h8, MSG_TRIG_IGN = 4'h9
  } msg_t;
  typedef enum logic [3:0] {
    ANS_SRC = 4'h0, ANS_CMP_OFF = 4'h1, ANS_CMP_NONE = 4'h2, ANS_CMP = 4'h3,
    ANS_VOLT = 4'h4, ANS_FREQ = 4'h5, ANS_TIME = 4'h6, ANS_STAT = 4'h7,
    ANS_VRANGE = 4'h8, ANS_PRANGE = 4'h9
  } ans_t;
  typedef enum logic [1:0] {
    FOP_LOAD = 2'h0, FOP_STORE = 2'h1, FOP_DELETE = 2'h2
  } file_op_t;
  localparam logic [9:0] VOLT_MIN = 10'h001;
  localparam logic [9:0] VOLT_MAX = 10'h0FF;
  localparam logic [9:0] PT_MIN = 10'h001;
  localparam logic [9:0] PT_MAX = 10'h258;
  localparam logic [9:0] REC_MIN = 10'h001;
  localparam logic [9:0] REC_MAX = 10'h03C;
  localparam int REC_COUNT = 60;
  localparam logic [3:0] NAME_MAX_LEN = 4'hB;
  localparam logic [87:0] DEFAULT_NAME = 88'h0000_0000_556E_6E61_6D65_64;
  localparam logic [31:0] CMP_OFF_CODE = 32'h0000_0002;
  localparam logic [31:0] CMP_NONE_CODE = 32'h0000_0003;
  localparam logic [31:0] VERDICT_PASS = 32'h0000_0001;
  localparam logic [31:0] VERDICT_FAIL = 32'h0000_0000;
  localparam logic [31:0] NO_VALUE_CODE = 32'hFFFF_FFFF;
  localparam logic [31:0] PD_OFF_CODE = 32'h0000_270F;
  localparam logic [1:0] PD_IDX = 2'h2;
  localparam logic [3:0] CMP_LAST = 4'h4;
  localparam logic [3:0] STAT_LAST = 4'h9;
  localparam logic [3:0] RANGE_LAST = 4'h1;
  localparam logic [7:0] VOLT_UPPER_RST = 8'hFF;
  localparam logic [7:0] VOLT_LOWER_RST = 8'h01;
  localparam logic [9:0] RANGE_START_RST = 10'h001;
  localparam logic [9:0] RANGE_END_RST = 10'h258;
endpackage : tester_cmd_pkg

// ==== hw/tester_remote_command_handler.sv ====
// Remote command handler: triggers, fetches, ranges, abort, setup files
`timescale 1ns/1ps
module tester_remote_command_handler
  import tester_cmd_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int PAGE_W = 2
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Decoded commands
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire cmd_t CMD_CODE,
  input wire logic [9:0] CMD_ARG0,
  input wire logic [9:0] CMD_ARG1,
  input wire logic [87:0] CMD_NAME,
  input wire logic [3:0] CMD_NAME_LEN,
  input wire logic CMD_SYNTAX_ERR,
  input wire logic CMD_EOL,
  // Answers
  output logic RSP_VALID,
  input wire logic RSP_READY,
  output logic [DATA_W-1:0] RSP_DATA,
  output logic RSP_LAST,
  output logic WAVE_SEND_REF,
  output logic WAVE_SEND_MEAS,
  // Measurement engine
  input wire logic PAGE_IS_MEAS,
  input wire logic KEY_START,
  input wire logic HANDLER_START_N,
  input wire logic MEAS_DONE,
  input wire logic REF_WAVE_READY,
  input wire logic MEAS_WAVE_READY,
  output logic MEAS_START,
  output logic MEAS_ABORT,
  output logic TESTING,
  // Results
  input wire logic COMP_ON,
  input wire logic [3:0] METHOD_ON,
  input wire logic RESULT_AVAIL,
  input wire logic PASS_ALL,
  input wire logic [4*DATA_W-1:0] METHOD_RESULT,
  input wire logic [DATA_W-1:0] VOLT_VALUE,
  input wire logic [DATA_W-1:0] FREQ_VALUE,
  input wire logic [DATA_W-1:0] TIME_VALUE,
  input wire logic FREQ_COINCIDE,
  input wire logic [10*DATA_W-1:0] STAT_DATA,
  // Settings
  output trig_src_t TRIG_SOURCE,
  output logic [7:0] VOLT_UPPER,
  output logic [7:0] VOLT_LOWER,
  output logic [9:0] RANGE_START,
  output logic [9:0] RANGE_END,
  // Setup files
  input wire logic [PAGE_W-1:0] PAGE_NOW,
  output logic FILE_GO,
  output file_op_t FILE_OP,
  output logic [5:0] FILE_NUM,
  output logic [87:0] FILE_NAME,
  output logic [PAGE_W-1:0] RESTORE_PAGE,
  output logic PAGE_RESTORE,
  // Messages
  output logic MSG_VALID,
  output msg_t MSG_CODE
);
  logic halt, rsp_busy, pend_ref, pend_meas, hs_q, auto_run;
  ans_t kind;
  logic [3:0] idx, last_idx;
  logic [REC_COUNT-1:0] occupied;
  logic [PAGE_W-1:0] page_mem [REC_COUNT];

  wire take = CMD_VALID && CMD_READY;
  wire base = take && !halt && !CMD_SYNTAX_ERR;
  wire syn_err = take && !halt && CMD_SYNTAX_ERR;
  wire is_trig = base && CMD_CODE == CMD_TRIG;
  wire is_src_set = base && CMD_CODE == CMD_SRC_SET;
  wire is_fref = base && CMD_CODE == CMD_FETCH_REF;
  wire is_fmeas = base && CMD_CODE == CMD_FETCH_MEAS;
  wire is_vset = base && CMD_CODE == CMD_VOLT_SET;
  wire is_pset = base && (CMD_CODE == CMD_FREQ_SET || CMD_CODE == CMD_TIME_SET);
  wire is_abort = base && CMD_CODE == CMD_ABORT;
  wire is_load = base && CMD_CODE == CMD_LOAD;
  wire is_store = base && CMD_CODE == CMD_STORE;
  wire is_del = base && CMD_CODE == CMD_DELETE;
  wire is_file = is_load || is_store || is_del;

  // Range checks on the decoded arguments
  wire v_rng = CMD_ARG0 < VOLT_MIN || CMD_ARG0 > VOLT_MAX ||
               CMD_ARG1 < VOLT_MIN || CMD_ARG1 > VOLT_MAX;
  wire v_ord = CMD_ARG1 >= CMD_ARG0;
  wire p_rng = CMD_ARG0 < PT_MIN || CMD_ARG0 > PT_MAX ||
               CMD_ARG1 < PT_MIN || CMD_ARG1 > PT_MAX;
  wire p_ord = CMD_ARG1 <= CMD_ARG0;
  wire rec_bad = CMD_ARG0 < REC_MIN || CMD_ARG0 > REC_MAX;
  wire name_long = CMD_NAME_LEN > NAME_MAX_LEN;
  wire [5:0] widx = CMD_ARG0[5:0] - 6'h01;
  wire file_ign = is_file && TESTING;
  wire file_ok = is_file && !TESTING && !rec_bad;
  wire v_ok = is_vset && !v_rng && !v_ord;
  wire p_ok = is_pset && !p_rng && !p_ord;
  wire store_ok = is_store && file_ok && !name_long;
  wire store_go = store_ok && REF_WAVE_READY;
  wire load_go = is_load && file_ok && occupied[widx];
  wire del_go = is_del && file_ok;
  wire perr = (is_vset && (v_rng || v_ord)) || (is_pset && (p_rng || p_ord)) ||
              (file_ok == 1'b0 && is_file && !TESTING) ||
              (is_store && file_ok && name_long);

  // Start sources; handler input is active low, so start on its release
  wire hs_rise = HANDLER_START_N && !hs_q;
  wire bus_go = is_trig && TRIG_SOURCE == SRC_BUS && PAGE_IS_MEAS && !TESTING;
  wire start_req = !TESTING && !is_abort && (bus_go ||
                   (TRIG_SOURCE == SRC_EXT && hs_rise) ||
                   (TRIG_SOURCE == SRC_MAN && KEY_START) || auto_run);
  wire next_testing = is_abort ? 1'b0 : start_req ? 1'b1 :
                      MEAS_DONE ? 1'b0 : TESTING;
  wire next_auto = (is_abort || is_src_set) ? 1'b0 :
                   (TRIG_SOURCE == SRC_INT && KEY_START) ? 1'b1 : auto_run;

  // Message selection, first match wins
  wire msg_t next_msg = syn_err ? MSG_SYNTAX :
    (is_vset && v_rng) || (is_pset && p_rng) ? MSG_RANGE :
    (is_vset && v_ord) || (is_pset && p_ord) ? MSG_ORDER :
    file_ign ? MSG_CMD_IGN :
    (is_file && rec_bad) ? MSG_FILE_RANGE :
    (is_store && file_ok && name_long) ? MSG_TOO_LONG :
    (store_ok && !REF_WAVE_READY) ? MSG_NEED_REF :
    (is_load && file_ok && !occupied[widx]) ? MSG_NO_FILE :
    (is_trig && !bus_go) ? MSG_TRIG_IGN : MSG_NONE;
  wire next_halt = CMD_EOL ? 1'b0 : (syn_err || perr) ? 1'b1 : halt;

  // Answer kind of the accepted query
  wire cmp_off = !COMP_ON || METHOD_ON == 4'h0;
  wire ans_t start_kind =
    CMD_CODE == CMD_SRC_Q ? ANS_SRC :
    CMD_CODE == CMD_FETCH_CMP ? (cmp_off ? ANS_CMP_OFF :
      (!RESULT_AVAIL ? ANS_CMP_NONE : ANS_CMP)) :
    CMD_CODE == CMD_FETCH_VOLT ? ANS_VOLT :
    CMD_CODE == CMD_FETCH_FREQ ? ANS_FREQ :
    CMD_CODE == CMD_FETCH_TIME ? ANS_TIME :
    CMD_CODE == CMD_FETCH_STAT ? ANS_STAT :
    CMD_CODE == CMD_VOLT_Q ? ANS_VRANGE : ANS_PRANGE;
  wire ans_go = base && (CMD_CODE == CMD_SRC_Q ||
    (CMD_CODE >= CMD_FETCH_CMP && CMD_CODE <= CMD_FETCH_STAT) ||
    CMD_CODE == CMD_VOLT_Q || CMD_CODE == CMD_FREQ_Q || CMD_CODE == CMD_TIME_Q);

  function automatic logic [3:0] last_of(input ans_t k);
    case (k)
      ANS_CMP: last_of = CMP_LAST;
      ANS_STAT: last_of = STAT_LAST;
      ANS_VRANGE, ANS_PRANGE: last_of = RANGE_LAST;
      default: last_of = 4'h0;
    endcase
  endfunction : last_of

  function automatic logic [DATA_W-1:0] word_of(input ans_t k, input logic [3:0] i);
    logic [1:0] m;
    m = 2'(i - 4'h1);
    case (k)
      ANS_SRC: word_of = DATA_W'(TRIG_SOURCE);
      ANS_CMP_OFF: word_of = DATA_W'(CMP_OFF_CODE);
      ANS_CMP_NONE: word_of = DATA_W'(CMP_NONE_CODE);
      ANS_CMP: word_of = (i == 4'h0) ?
        DATA_W'(PASS_ALL ? VERDICT_PASS : VERDICT_FAIL) :
        METHOD_ON[m] ? METHOD_RESULT[m*DATA_W +: DATA_W] :
        DATA_W'(m == PD_IDX ? PD_OFF_CODE : NO_VALUE_CODE);
      ANS_VOLT: word_of = VOLT_VALUE;
      ANS_FREQ: word_of = FREQ_COINCIDE ? DATA_W'(NO_VALUE_CODE) : FREQ_VALUE;
      ANS_TIME: word_of = TIME_VALUE;
      ANS_STAT: word_of = STAT_DATA[i*DATA_W +: DATA_W];
      ANS_VRANGE: word_of = DATA_W'(i == 4'h0 ? VOLT_UPPER : VOLT_LOWER);
      ANS_PRANGE: word_of = DATA_W'(i == 4'h0 ? RANGE_START : RANGE_END);
      default: word_of = '0;
    endcase
  endfunction : word_of

  // Queries stall the command stream until their answer is drained
  assign CMD_READY = !rsp_busy;
  assign RSP_VALID = rsp_busy;
  assign RSP_LAST = rsp_busy && idx == last_idx;
  wire step = rsp_busy && RSP_READY && !RSP_LAST;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rsp_busy <= 1'b0;
      kind <= ANS_SRC;
      idx <= 4'h0;
      last_idx <= 4'h0;
      RSP_DATA <= '0;
    end else if (ans_go) begin
      rsp_busy <= 1'b1;
      kind <= start_kind;
      idx <= 4'h0;
      last_idx <= last_of(start_kind);
      RSP_DATA <= word_of(start_kind, 4'h0);
    end else if (step) begin
      idx <= idx + 4'h1;
      RSP_DATA <= word_of(kind, idx + 4'h1);
    end else if (RSP_LAST && RSP_READY) begin
      rsp_busy <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      halt <= 1'b0;
      hs_q <= 1'b1;
      auto_run <= 1'b0;
      TESTING <= 1'b0;
      MEAS_START <= 1'b0;
      MEAS_ABORT <= 1'b0;
    end else begin
      halt <= next_halt;
      hs_q <= HANDLER_START_N;
      auto_run <= next_auto;
      TESTING <= next_testing;
      MEAS_START <= start_req;
      MEAS_ABORT <= is_abort;
    end
  end

  // A held fetch is answered by the next measurement completion
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_ref <= 1'b0;
      pend_meas <= 1'b0;
      WAVE_SEND_REF <= 1'b0;
      WAVE_SEND_MEAS <= 1'b0;
    end else begin
      WAVE_SEND_REF <= (is_fref && REF_WAVE_READY) || (pend_ref && MEAS_DONE);
      WAVE_SEND_MEAS <= (is_fmeas && MEAS_WAVE_READY) || (pend_meas && MEAS_DONE);
      pend_ref <= (is_fref && !REF_WAVE_READY) || (pend_ref && !MEAS_DONE);
      pend_meas <= (is_fmeas && !MEAS_WAVE_READY) || (pend_meas && !MEAS_DONE);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TRIG_SOURCE <= SRC_MAN;
      VOLT_UPPER <= VOLT_UPPER_RST;
      VOLT_LOWER <= VOLT_LOWER_RST;
      RANGE_START <= RANGE_START_RST;
      RANGE_END <= RANGE_END_RST;
      MSG_VALID <= 1'b0;
      MSG_CODE <= MSG_NONE;
    end else begin
      if (is_src_set) TRIG_SOURCE <= trig_src_t'(CMD_ARG0[1:0]);
      if (v_ok) VOLT_UPPER <= CMD_ARG0[7:0];
      if (v_ok) VOLT_LOWER <= CMD_ARG1[7:0];
      if (p_ok) RANGE_START <= CMD_ARG0;
      if (p_ok) RANGE_END <= CMD_ARG1;
      MSG_VALID <= next_msg != MSG_NONE;
      MSG_CODE <= next_msg;
    end
  end

  // Record table: occupancy and the page saved with each record
  for (genvar g = 0; g < REC_COUNT; g++) begin : g_rec
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        occupied[g] <= 1'b0;
        page_mem[g] <= '0;
      end else if (store_go && widx == 6'(g)) begin
        occupied[g] <= 1'b1;
        page_mem[g] <= PAGE_NOW;
      end else if (del_go && widx == 6'(g)) begin
        occupied[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FILE_GO <= 1'b0;
      FILE_OP <= FOP_LOAD;
      FILE_NUM <= 6'h00;
      FILE_NAME <= '0;
      RESTORE_PAGE <= '0;
      PAGE_RESTORE <= 1'b0;
    end else begin
      FILE_GO <= store_go || load_go || del_go;
      PAGE_RESTORE <= load_go;
      if (store_go || load_go || del_go) begin
        FILE_NUM <= CMD_ARG0[5:0];
        FILE_OP <= store_go ? FOP_STORE : load_go ? FOP_LOAD : FOP_DELETE;
        FILE_NAME <= CMD_NAME_LEN == 4'h0 ? DEFAULT_NAME : CMD_NAME;
      end
      if (load_go) RESTORE_PAGE <= page_mem[widx];
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_trig_busy;
    is_trig && (TESTING || !PAGE_IS_MEAS) && TRIG_SOURCE == SRC_BUS |=> !MEAS_START;
  endproperty
  a_trig_busy: assert property (p_trig_busy) else $error("bus trigger not discarded");
  property p_trig_src;
    is_trig && TRIG_SOURCE != SRC_BUS |=> MSG_VALID && MSG_CODE == MSG_TRIG_IGN;
  endproperty
  a_trig_src: assert property (p_trig_src) else $error("trigger source not checked");
  property p_pend;
    pend_ref && MEAS_DONE |=> WAVE_SEND_REF && !pend_ref;
  endproperty
  a_pend: assert property (p_pend) else $error("held fetch not answered");
  property p_cmp_off;
    base && CMD_CODE == CMD_FETCH_CMP && cmp_off |=> RSP_LAST && RSP_DATA == CMP_OFF_CODE;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("comparator off answer wrong");
  property p_vorder;
    is_vset && !v_rng && v_ord |=> $stable(VOLT_UPPER) && MSG_CODE == MSG_ORDER;
  endproperty
  a_vorder: assert property (p_vorder) else $error("voltage order not refused");
  property p_shared;
    p_ok |=> RANGE_START == $past(CMD_ARG0) && RANGE_END == $past(CMD_ARG1);
  endproperty
  a_shared: assert property (p_shared) else $error("shared range not set");
  property p_abort;
    is_abort |=> !TESTING && MEAS_ABORT ##1 !MEAS_ABORT || is_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not honoured");
  property p_file_ign;
    is_file && TESTING |=> !FILE_GO && MSG_CODE == MSG_CMD_IGN;
  endproperty
  a_file_ign: assert property (p_file_ign) else $error("file command while testing");
  property p_halt;
    take && halt && !CMD_EOL |=> $stable(TRIG_SOURCE) && !FILE_GO && !MEAS_ABORT;
  endproperty
  a_halt: assert property (p_halt) else $error("command after parse error ran");
  property p_flag;
    MEAS_START |-> TESTING;
  endproperty
  a_flag: assert property (p_flag) else $error("start without testing flag");
endmodule : tester_remote_command_handler

// ==== verification/host_cmd_model.sv ====
// Host controller model: issues decoded commands and drains answers
`timescale 1ns/1ps
module host_cmd_model
  import tester_cmd_pkg::*;
(
  // Clock and command handshake
  input wire logic clk,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output cmd_t cmd_code,
  output logic [9:0] cmd_arg0,
  output logic [9:0] cmd_arg1,
  output logic [87:0] cmd_name,
  output logic [3:0] cmd_name_len,
  output logic cmd_syntax_err,
  output logic cmd_eol,
  // Answer stream
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  input wire logic rsp_last,
  output logic rsp_ready,
  // Stuck handshake seen
  output logic hung
);
  logic [31:0] words[$];
  int lastpos;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = CMD_ABORT;
    cmd_arg0 = 10'h0;
    cmd_arg1 = 10'h0;
    cmd_name = 88'h0;
    cmd_name_len = 4'h0;
    cmd_syntax_err = 1'b0;
    cmd_eol = 1'b0;
    rsp_ready = 1'b1;
    hung = 1'b0;
  end
  // Held from a falling edge until the rising edge that takes it
  task automatic send(input cmd_t c, input logic [9:0] a0, input logic [9:0] a1,
                      input logic [87:0] nm, input logic [3:0] nl, input logic se);
    int k;
    k = 0;
    @(negedge clk);
    cmd_code = c;
    cmd_arg0 = a0;
    cmd_arg1 = a1;
    cmd_name = nm;
    cmd_name_len = nl;
    cmd_syntax_err = se;
    cmd_valid = 1'b1;
    #1;
    while (!cmd_ready && k < 40) begin
      @(negedge clk);
      #1;
      k++;
    end
    if (k == 40) hung = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_syntax_err = 1'b0;
    // Released argument and name lines must not keep their old value
    cmd_arg0 = ~a0;
    cmd_arg1 = ~a1;
    cmd_name = ~nm;
  endtask : send
  task automatic eol();
    @(negedge clk);
    cmd_eol = 1'b1;
    @(negedge clk);
    cmd_eol = 1'b0;
  endtask : eol
  // Slow mode stalls one cycle before taking each word
  task automatic collect(input bit slow);
    words.delete();
    lastpos = -1;
    for (int i = 0; i < 12 && rsp_valid; i++) begin
      if (slow) begin
        rsp_ready = 1'b0;
        @(negedge clk);
        rsp_ready = 1'b1;
      end
      words.push_back(rsp_data);
      if (rsp_last) lastpos = i;
      @(negedge clk);
    end
    if (rsp_valid) hung = 1'b1;
  endtask : collect
endmodule : host_cmd_model

// ==== verification/test_tester_remote_command_handler.sv ====
// Self-checking bench for the remote command handler
`timescale 1ns/1ps
module test_tester_remote_command_handler
  import tester_cmd_pkg::*;
;
  typedef struct {cmd_t c; logic [9:0] a0; logic [9:0] a1; msg_t m; logic q;} row_t;
  logic CLK = 1'b0, RST_N = 1'b0, CMD_VALID, CMD_READY, CMD_SYNTAX_ERR, CMD_EOL, hung;
  logic RSP_VALID, RSP_READY, RSP_LAST, WAVE_SEND_REF, WAVE_SEND_MEAS, MEAS_START, got;
  logic MEAS_ABORT, TESTING, FILE_GO, PAGE_RESTORE, MSG_VALID;
  logic PAGE_IS_MEAS = 1'b1, KEY_START = 1'b0, HANDLER_START_N = 1'b1, MEAS_DONE = 1'b0;
  logic REF_WAVE_READY = 1'b1, MEAS_WAVE_READY = 1'b1, COMP_ON = 1'b0, RESULT_AVAIL = 1'b0;
  logic PASS_ALL = 1'b1, FREQ_COINCIDE = 1'b0;
  logic [3:0] METHOD_ON = 4'hF, CMD_NAME_LEN;
  logic [9:0] CMD_ARG0, CMD_ARG1, RANGE_START, RANGE_END;
  logic [87:0] CMD_NAME, FILE_NAME;
  logic [31:0] RSP_DATA, VOLT_VALUE = 32'h64, FREQ_VALUE = 32'h1234, TIME_VALUE = 32'h55;
  logic [127:0] METHOD_RESULT = 128'h0000_0044_0000_0033_0000_0022_0000_0011;
  logic [319:0] STAT_DATA;
  logic [7:0] VOLT_UPPER, VOLT_LOWER;
  logic [5:0] FILE_NUM;
  logic [1:0] PAGE_NOW = 2'h2, RESTORE_PAGE;
  cmd_t CMD_CODE;
  trig_src_t TRIG_SOURCE;
  file_op_t FILE_OP;
  msg_t MSG_CODE;
  logic [31:0] stat_q[$];
  int err_count = 0, checks_done = 0;
  row_t rows[15] = '{
    '{CMD_VOLT_SET, 10'h0C8, 10'h00A, MSG_NONE, 1'b0},
    '{CMD_VOLT_Q, 10'h0C8, 10'h00A, MSG_NONE, 1'b1},
    '{CMD_VOLT_SET, 10'h00A, 10'h00A, MSG_ORDER, 1'b0},
    '{CMD_VOLT_SET, 10'h100, 10'h001, MSG_RANGE, 1'b0},
    '{CMD_VOLT_SET, 10'h0FF, 10'h000, MSG_RANGE, 1'b0},
    '{CMD_VOLT_Q, 10'h0C8, 10'h00A, MSG_NONE, 1'b1},
    '{CMD_FREQ_SET, 10'h064, 10'h0C8, MSG_NONE, 1'b0},
    '{CMD_TIME_Q, 10'h064, 10'h0C8, MSG_NONE, 1'b1},
    '{CMD_TIME_SET, 10'h258, 10'h258, MSG_ORDER, 1'b0},
    '{CMD_TIME_SET, 10'h001, 10'h259, MSG_RANGE, 1'b0},
    '{CMD_TIME_SET, 10'h001, 10'h258, MSG_NONE, 1'b0},
    '{CMD_FREQ_Q, 10'h001, 10'h258, MSG_NONE, 1'b1},
    '{CMD_LOAD, 10'h000, 10'h000, MSG_FILE_RANGE, 1'b0},
    '{CMD_LOAD, 10'h03D, 10'h000, MSG_FILE_RANGE, 1'b0},
    '{CMD_LOAD, 10'h03C, 10'h000, MSG_NO_FILE, 1'b0}
  };
  tester_remote_command_handler dut (
    .CLK, .RST_N, .CMD_VALID, .CMD_READY, .CMD_CODE, .CMD_ARG0, .CMD_ARG1, .CMD_NAME,
    .CMD_NAME_LEN, .CMD_SYNTAX_ERR, .CMD_EOL, .RSP_VALID, .RSP_READY, .RSP_DATA, .RSP_LAST,
    .WAVE_SEND_REF, .WAVE_SEND_MEAS, .PAGE_IS_MEAS, .KEY_START, .HANDLER_START_N, .MEAS_DONE,
    .REF_WAVE_READY, .MEAS_WAVE_READY, .MEAS_START, .MEAS_ABORT, .TESTING, .COMP_ON,
    .METHOD_ON, .RESULT_AVAIL, .PASS_ALL, .METHOD_RESULT, .VOLT_VALUE, .FREQ_VALUE,
    .TIME_VALUE, .FREQ_COINCIDE, .STAT_DATA, .TRIG_SOURCE, .VOLT_UPPER, .VOLT_LOWER,
    .RANGE_START, .RANGE_END, .PAGE_NOW, .FILE_GO, .FILE_OP, .FILE_NUM, .FILE_NAME,
    .RESTORE_PAGE, .PAGE_RESTORE, .MSG_VALID, .MSG_CODE
  );
  host_cmd_model host (
    .clk(CLK), .cmd_ready(CMD_READY), .cmd_valid(CMD_VALID), .cmd_code(CMD_CODE),
    .cmd_arg0(CMD_ARG0), .cmd_arg1(CMD_ARG1), .cmd_name(CMD_NAME),
    .cmd_name_len(CMD_NAME_LEN), .cmd_syntax_err(CMD_SYNTAX_ERR), .cmd_eol(CMD_EOL),
    .rsp_valid(RSP_VALID), .rsp_data(RSP_DATA), .rsp_last(RSP_LAST),
    .rsp_ready(RSP_READY), .hung(hung)
  );
  always #4 CLK = ~CLK;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cmd(input cmd_t c, input logic [9:0] a0, input logic [9:0] a1);
    host.send(c, a0, a1, 88'h0, 4'h0, 1'b0);
  endtask : cmd
  // Whole answer: word count, last marker and every word
  task automatic ans(input cmd_t c, input bit slow, input logic [31:0] e[$]);
    cmd(c, 10'h0, 10'h0);
    host.collect(slow);
    check("count", 32'(host.words.size()), 32'(e.size()));
    check("last", 32'(host.lastpos), 32'(e.size() - 1));
    foreach (e[i]) check("word", host.words[i], e[i]);
  endtask : ans
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // A stuck handshake ends the run at once
  always @(posedge hung) begin
    err_count++;
    end_of_test();
  end
  initial begin
    for (int i = 0; i < 10; i++) begin
      STAT_DATA[i*32+:32] = 32'(i + 16);
      stat_q.push_back(32'(i + 16));
    end
    repeat (10) @(negedge CLK);
    RST_N = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].q) ans(rows[i].c, 1'b0, '{32'(rows[i].a0), 32'(rows[i].a1)});
      else begin
        cmd(rows[i].c, rows[i].a0, rows[i].a1);
        check("msg", 32'(MSG_CODE), 32'(rows[i].m));
        check("valid", 32'(MSG_VALID), 32'(rows[i].m != MSG_NONE));
      end
      host.eol();
    end
    $display("range and record table done");
    for (int s = 3; s >= 0; s--) begin
      cmd(CMD_SRC_SET, 10'(s), 10'h0);
      ans(CMD_SRC_Q, 1'b0, '{32'(s)});
    end
    cmd(CMD_TRIG, 10'h0, 10'h0);
    check("start", 32'(MEAS_START), 32'h0);
    cmd(CMD_SRC_SET, 10'h3, 10'h0);
    PAGE_IS_MEAS = 1'b0;
    cmd(CMD_TRIG, 10'h0, 10'h0);
    check("start", 32'(MEAS_START), 32'h0);
    PAGE_IS_MEAS = 1'b1;
    MEAS_WAVE_READY = 1'b0;
    REF_WAVE_READY = 1'b0;
    cmd(CMD_TRIG, 10'h0, 10'h0);
    check("start", 32'(MEAS_START), 32'h1);
    cmd(CMD_FETCH_REF, 10'h0, 10'h0);
    cmd(CMD_FETCH_MEAS, 10'h0, 10'h0);
    check("testing", 32'(TESTING), 32'h1);
    check("wave", 32'({WAVE_SEND_REF, WAVE_SEND_MEAS}), 32'h0);
    cmd(CMD_TRIG, 10'h0, 10'h0);
    check("msg", 32'(MSG_CODE), 32'(MSG_TRIG_IGN));
    check("start", 32'(MEAS_START), 32'h0);
    cmd(CMD_STORE, 10'h1, 10'h0);
    check("msg", 32'(MSG_CODE), 32'(MSG_CMD_IGN));
    check("go", 32'(FILE_GO), 32'h0);
    MEAS_DONE = 1'b1;
    @(negedge CLK);
    MEAS_DONE = 1'b0;
    check("wave", 32'({WAVE_SEND_REF, WAVE_SEND_MEAS}), 32'h3);
    REF_WAVE_READY = 1'b1;
    check("testing", 32'(TESTING), 32'h0);
    cmd(CMD_FETCH_REF, 10'h0, 10'h0);
    check("wave", 32'(WAVE_SEND_REF), 32'h1);
    cmd(CMD_TRIG, 10'h0, 10'h0);
    cmd(CMD_ABORT, 10'h0, 10'h0);
    check("abort", 32'(MEAS_ABORT), 32'h1);
    @(negedge CLK);
    check("testing", 32'(TESTING), 32'h0);
    $display("trigger test done");
    ans(CMD_FETCH_CMP, 1'b0, '{CMP_OFF_CODE});
    COMP_ON = 1'b1;
    METHOD_ON = 4'h0;
    ans(CMD_FETCH_CMP, 1'b0, '{CMP_OFF_CODE});
    METHOD_ON = 4'hB;
    ans(CMD_FETCH_CMP, 1'b0, '{CMP_NONE_CODE});
    RESULT_AVAIL = 1'b1;
    ans(CMD_FETCH_CMP, 1'b1, '{VERDICT_PASS, 32'h11, 32'h22, PD_OFF_CODE, 32'h44});
    PASS_ALL = 1'b0;
    METHOD_ON = 4'h4;
    ans(CMD_FETCH_CMP, 1'b1, '{VERDICT_FAIL, NO_VALUE_CODE, NO_VALUE_CODE, 32'h33,
        NO_VALUE_CODE});
    ans(CMD_FETCH_STAT, 1'b1, stat_q);
    ans(CMD_FETCH_VOLT, 1'b0, '{32'h64});
    ans(CMD_FETCH_TIME, 1'b0, '{32'h55});
    ans(CMD_FETCH_FREQ, 1'b0, '{32'h1234});
    FREQ_COINCIDE = 1'b1;
    ans(CMD_FETCH_FREQ, 1'b0, '{NO_VALUE_CODE});
    $display("fetch test done");
    cmd(CMD_SRC_SET, 10'h2, 10'h0);
    HANDLER_START_N = 1'b0;
    repeat (2) @(negedge CLK);
    check("start", 32'(MEAS_START), 32'h0);
    HANDLER_START_N = 1'b1;
    got = 1'b0;
    repeat (3) begin
      @(negedge CLK);
      got = got | MEAS_START;
    end
    check("start", 32'(got), 32'h1);
    cmd(CMD_ABORT, 10'h0, 10'h0);
    for (int s = 0; s < 2; s++) begin
      cmd(CMD_SRC_SET, 10'(s), 10'h0);
      KEY_START = 1'b1;
      @(negedge CLK);
      KEY_START = 1'b0;
      if (s == 1) @(negedge CLK);
      check("key", 32'(MEAS_START), 32'h1);
      MEAS_DONE = 1'b1;
      @(negedge CLK);
      MEAS_DONE = 1'b0;
      @(negedge CLK);
      check("repeat", 32'(MEAS_START), 32'(s));
      cmd(CMD_ABORT, 10'h0, 10'h0);
    end
    $display("handler test done");
    REF_WAVE_READY = 1'b0;
    cmd(CMD_STORE, 10'h7, 10'h0);
    check("msg", 32'(MSG_CODE), 32'(MSG_NEED_REF));
    check("go", 32'(FILE_GO), 32'h0);
    REF_WAVE_READY = 1'b1;
    cmd(CMD_STORE, 10'h7, 10'h0);
    check("store", 32'({FILE_GO, FILE_OP, FILE_NUM}), 32'({1'b1, FOP_STORE, 6'h07}));
    check("name", 32'(FILE_NAME !== DEFAULT_NAME), 32'h0);
    host.send(CMD_STORE, 10'h7, 10'h0, 88'h61_6263_6465_6667_6869_6A6B, 4'hB, 1'b0);
    check("msg", 32'(MSG_CODE), 32'(MSG_NONE));
    check("name", 32'(FILE_NAME !== 88'h61_6263_6465_6667_6869_6A6B), 32'h0);
    host.send(CMD_STORE, 10'h7, 10'h0, 88'h6162, 4'hC, 1'b0);
    check("msg", 32'(MSG_CODE), 32'(MSG_TOO_LONG));
    host.eol();
    PAGE_NOW = 2'h1;
    cmd(CMD_LOAD, 10'h7, 10'h0);
    check("load", 32'({PAGE_RESTORE, RESTORE_PAGE, FILE_OP}), 32'({1'b1, 2'h2, FOP_LOAD}));
    cmd(CMD_DELETE, 10'h7, 10'h0);
    check("del", 32'({MSG_CODE, FILE_GO, FILE_OP}), 32'({MSG_NONE, 1'b1, FOP_DELETE}));
    cmd(CMD_LOAD, 10'h7, 10'h0);
    check("msg", 32'(MSG_CODE), 32'(MSG_NO_FILE));
    $display("file test done");
    host.send(CMD_VOLT_SET, 10'h032, 10'h005, 88'h0, 4'h0, 1'b1);
    check("msg", 32'(MSG_CODE), 32'(MSG_SYNTAX));
    cmd(CMD_VOLT_SET, 10'h032, 10'h005);
    check("upper", 32'(VOLT_UPPER), 32'hC8);
    host.eol();
    cmd(CMD_VOLT_SET, 10'h032, 10'h005);
    check("upper", 32'(VOLT_UPPER), 32'h32);
    $display("halt test done");
    RST_N = 1'b0;
    @(negedge CLK);
    check("rst", 32'({TRIG_SOURCE, VOLT_UPPER, VOLT_LOWER, TESTING}),
          32'({SRC_MAN, VOLT_UPPER_RST, VOLT_LOWER_RST, 1'b0}));
    check("rst", 32'({RANGE_START, RANGE_END}), 32'({RANGE_START_RST, RANGE_END_RST}));
    RST_N = 1'b1;
    $display("reset test done");
    end_of_test();
  end
endmodule : test_tester_remote_command_handler
